/* File: design/fmhc_pkg.sv */
// Constants, timing counts and state type of the host-side memory bus controller.
// Assumes a single 20 MHz system clock; all pin timing is expressed in its cycles.
package fmhc_pkg;
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int REQ_ADDR_W = 19;
  localparam int WCNT_W = 4;
  localparam int PU_W = 14;

  // Clock period and printed pin timing
  localparam int CLK_NS = 50;
  localparam int T_AA_NS = 110;
  localparam int T_AAP_NS = 25;
  localparam int T_PC_NS = 55;
  localparam int T_PAGE_NS = 25;
  localparam int T_PU_US = 450;

  // Least times round up to whole cycles
  localparam logic [WCNT_W-1:0] CYC_AA = WCNT_W'((T_AA_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [WCNT_W-1:0] CYC_AAP = WCNT_W'((T_AAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [WCNT_W-1:0] CYC_PC = WCNT_W'((T_PC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [WCNT_W-1:0] CYC_PAGE = WCNT_W'((T_PAGE_NS + CLK_NS - 1) / CLK_NS);
  // Extra wait so read data has crossed the two-flop input synchroniser
  localparam logic [WCNT_W-1:0] CYC_SYNC = 4'h2;
  localparam int PU_CYC_DEF = (T_PU_US * 1000) / CLK_NS;

  localparam logic [1:0] LANES_OFF = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_ACC = 3'b011,
    ST_END = 3'b010,
    ST_PREC = 3'b110
  } fmhc_state_t;
endpackage : fmhc_pkg

/* File: design/fmhc_wait_if.sv */
// Interface between the controller sequencer and its wait timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ns
interface fmhc_wait_if;
  import fmhc_pkg::*;
  logic load;
  logic [WCNT_W-1:0] count;
  logic done;
  modport ctrl (output load, output count, input done);
  modport tmr (input load, input count, output done);
endinterface : fmhc_wait_if

/* File: design/fmhc_wait.sv */
// Down-counting wait timer used for access, page and precharge intervals.
// Assumes load is a one-cycle pulse and count is at least one.
`timescale 1ns/1ns
module fmhc_wait (
  input wire logic clk,
  input wire logic rst,
  fmhc_wait_if.tmr wt
);
  import fmhc_pkg::*;

  logic [WCNT_W-1:0] cnt_ff;
  logic [WCNT_W-1:0] nxt_cnt;

  // Next count: reload wins over decrement
  always_comb begin
    nxt_cnt = cnt_ff;
    if (wt.load) begin
      nxt_cnt = wt.count;
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  // Done in the last of count cycles after the load
  assign wt.done = (cnt_ff <= 4'h1) && !wt.load;

  property p_wait_reload;
    @(posedge clk) disable iff (rst)
      (wt.load && wt.count == 4'h3) |=> !wt.done ##1 !wt.done ##1 wt.done;
  endproperty
  a_wait_reload: assert property (p_wait_reload) else $error("wait timer length wrong");
endmodule : fmhc_wait

/* File: design/fmhc_ctrl.sv */
// Host-side controller for an asynchronous 256Kx16 nonvolatile SRAM-style memory.
// Assumes the board resolves MEM_DQ from MEM_DQ_O and MEM_DQ_OE, and PWR_OK is an async pin.
// Operation
// [R01] Held-low enable: address change starts access
// [R02] Enable may stay low without limit
// [R03] Page accesses never faster than 40MHz
// [R04] Write enable high through power transitions
// [R05] Enable stays driven so protection sequence works
// [R06] Release enable between accesses for low power
// [R07] Enable may pulse low per access
// [R08] Byte selects gate data lanes both directions
// [R09] Byte-wide mode: lanes tied, selects from A18
// [R10] Low two address bits choose page column
// [R11] Row change waits full address access time
// [R12] Byte-wide: exactly one select per access
`timescale 1ns/1ns
module fmhc_ctrl #(
  parameter int PU_CYC = fmhc_pkg::PU_CYC_DEF
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic PWR_OK,
  input wire logic KEEP_CE,
  input wire logic BYTE_MODE,
  input wire logic REQ_VALID,
  output logic REQ_READY,
  input wire logic REQ_WRITE,
  input wire logic [fmhc_pkg::REQ_ADDR_W-1:0] REQ_ADDR,
  input wire logic [fmhc_pkg::DATA_W-1:0] REQ_WDATA,
  input wire logic [1:0] REQ_BE,
  output logic RSP_VALID,
  output logic [fmhc_pkg::DATA_W-1:0] RSP_RDATA,
  output logic MEM_CE_N,
  output logic MEM_WE_N,
  output logic MEM_OE_N,
  output logic MEM_HIGH_BYTE_SELECT_N,
  output logic MEM_LOW_BYTE_SELECT_N,
  output logic [fmhc_pkg::ADDR_W-1:0] MEM_ADDR,
  input wire logic [fmhc_pkg::DATA_W-1:0] MEM_DQ_I,
  output logic [fmhc_pkg::DATA_W-1:0] MEM_DQ_O,
  output logic MEM_DQ_OE
);
  import fmhc_pkg::*;

  // Byte lane selects, active low, {high, low}
  function automatic logic [1:0] lane_sel(input logic bm, input logic a18,
                                          input logic [1:0] be);
    lane_sel = bm ? {!a18, a18} : ~be;
  endfunction : lane_sel

  fmhc_wait_if wt ();
  fmhc_wait u_wait (.clk(SYS_CLK), .rst(SYS_RST), .wt(wt));

  logic pwr_s1_ff, pwr_s2_ff;
  logic [DATA_W-1:0] dq_s1_ff, dq_s2_ff;
  logic [PU_W-1:0] pu_cnt_ff, nxt_pu_cnt;
  logic pwr_ready_ff, nxt_pwr_ready;
  fmhc_state_t state_ff, nxt_state;
  logic ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n;
  logic [1:0] lanes_ff, nxt_lanes;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] dq_o_ff, nxt_dq_o, rdata_ff, nxt_rdata;
  logic dq_oe_ff, nxt_dq_oe, wr_ff, nxt_wr, long_ff, nxt_long, keep_ff, nxt_keep;
  logic bsel_ff, nxt_bsel, bm_ff, nxt_bm, rsp_ff, nxt_rsp;

  // Two-flop synchronisers for pins outside the clock domain
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pwr_s1_ff <= 1'b0;
      pwr_s2_ff <= 1'b0;
      dq_s1_ff <= '0;
      dq_s2_ff <= '0;
    end else begin
      pwr_s1_ff <= PWR_OK;
      pwr_s2_ff <= pwr_s1_ff;
      dq_s1_ff <= MEM_DQ_I;
      dq_s2_ff <= dq_s1_ff;
    end
  end

  // Power-up settle count; any supply dip restarts it
  always_comb begin
    nxt_pu_cnt = pu_cnt_ff;
    nxt_pwr_ready = pwr_ready_ff;
    if (!pwr_s2_ff) begin
      nxt_pu_cnt = '0;
      nxt_pwr_ready = 1'b0;
    end else if (pu_cnt_ff == PU_W'(PU_CYC - 1)) begin
      nxt_pwr_ready = 1'b1;
    end else begin
      nxt_pu_cnt = pu_cnt_ff + 14'h1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pu_cnt_ff <= '0;
      pwr_ready_ff <= 1'b0;
    end else begin
      pu_cnt_ff <= nxt_pu_cnt;
      pwr_ready_ff <= nxt_pwr_ready;
    end
  end

  assign REQ_READY = (state_ff == ST_IDLE) && pwr_ready_ff;

  // Access sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_ce_n = ce_n_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_lanes = lanes_ff;
    nxt_addr = addr_ff;
    nxt_dq_o = dq_o_ff;
    nxt_dq_oe = dq_oe_ff;
    nxt_rdata = rdata_ff;
    nxt_wr = wr_ff;
    nxt_long = long_ff;
    nxt_keep = keep_ff;
    nxt_bsel = bsel_ff;
    nxt_bm = bm_ff;
    nxt_rsp = 1'b0;
    wt.load = 1'b0;
    wt.count = CYC_PAGE;
    case (state_ff)
      ST_IDLE: begin
        if (REQ_VALID && REQ_READY) begin
          // Same row with enable still low is a page access
          nxt_long = ce_n_ff || (addr_ff[ADDR_W-1:2] != REQ_ADDR[ADDR_W-1:2]); // R10 R11
          nxt_addr = REQ_ADDR[ADDR_W-1:0]; // R01
          nxt_ce_n = 1'b0; // R07
          nxt_wr = REQ_WRITE;
          nxt_oe_n = REQ_WRITE;
          nxt_lanes = lane_sel(BYTE_MODE, REQ_ADDR[ADDR_W], REQ_BE); // R08 R12
          // Tied lanes carry the same byte on both halves
          nxt_dq_o = BYTE_MODE ? {2{REQ_WDATA[7:0]}} : REQ_WDATA; // R09
          nxt_bsel = BYTE_MODE && REQ_ADDR[ADDR_W];
          nxt_bm = BYTE_MODE;
          nxt_keep = KEEP_CE;
          nxt_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        // Address settles a cycle before write enable falls
        wt.load = 1'b1;
        wt.count = (long_ff ? CYC_AA : CYC_PAGE) + (wr_ff ? 4'h0 : CYC_SYNC); // R03 R11
        nxt_we_n = !wr_ff;
        nxt_dq_oe = wr_ff;
        nxt_state = ST_ACC;
      end
      ST_ACC: begin
        if (wt.done) begin
          nxt_we_n = 1'b1;
          nxt_rsp = 1'b1;
          if (!wr_ff) begin
            nxt_rdata = !bm_ff ? dq_s2_ff :
                        bsel_ff ? {8'h00, dq_s2_ff[15:8]} : {8'h00, dq_s2_ff[7:0]}; // R08
          end
          nxt_state = ST_END;
        end
      end
      ST_END: begin
        // Data held one cycle past write enable rising
        nxt_dq_oe = 1'b0;
        nxt_oe_n = 1'b1;
        nxt_lanes = LANES_OFF;
        if (keep_ff) begin
          nxt_state = ST_IDLE; // R02
        end else begin
          nxt_ce_n = 1'b1; // R06 R07
          wt.load = 1'b1;
          wt.count = CYC_PC;
          nxt_state = ST_PREC;
        end
      end
      ST_PREC: begin
        if (wt.done) begin
          nxt_state = ST_IDLE;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    // Supply not settled: park with chip, write and output enables all high, abandoning any access
    if (!pwr_ready_ff) begin
      nxt_state = ST_IDLE;
      nxt_ce_n = 1'b1; // R04 R05
      nxt_we_n = 1'b1; // R04
      nxt_oe_n = 1'b1;
      nxt_dq_oe = 1'b0;
      nxt_lanes = LANES_OFF;
      nxt_rsp = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_ff <= ST_IDLE;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      lanes_ff <= LANES_OFF;
      addr_ff <= '0;
      dq_o_ff <= '0;
      dq_oe_ff <= 1'b0;
      rdata_ff <= '0;
      wr_ff <= 1'b0;
      long_ff <= 1'b1;
      keep_ff <= 1'b0;
      bsel_ff <= 1'b0;
      bm_ff <= 1'b0;
      rsp_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ce_n_ff <= nxt_ce_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      lanes_ff <= nxt_lanes;
      addr_ff <= nxt_addr;
      dq_o_ff <= nxt_dq_o;
      dq_oe_ff <= nxt_dq_oe;
      rdata_ff <= nxt_rdata;
      wr_ff <= nxt_wr;
      long_ff <= nxt_long;
      keep_ff <= nxt_keep;
      bsel_ff <= nxt_bsel;
      bm_ff <= nxt_bm;
      rsp_ff <= nxt_rsp;
    end
  end

  assign MEM_CE_N = ce_n_ff;
  assign MEM_WE_N = we_n_ff;
  assign MEM_OE_N = oe_n_ff;
  assign MEM_HIGH_BYTE_SELECT_N = lanes_ff[1];
  assign MEM_LOW_BYTE_SELECT_N = lanes_ff[0];
  assign MEM_ADDR = addr_ff;
  assign MEM_DQ_O = dq_o_ff;
  assign MEM_DQ_OE = dq_oe_ff;
  assign RSP_VALID = rsp_ff;
  assign RSP_RDATA = rdata_ff;

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);

  property p_we_pwr;
    !pwr_ready_ff |=> MEM_WE_N && MEM_CE_N;
  endproperty
  a_we_pwr: assert property (p_we_pwr) else $error("enables low while supply unsettled"); // R04

  property p_row_write;
    (state_ff == ST_SETUP && wr_ff && long_ff && pwr_ready_ff)
      |=> (state_ff == ST_ACC && !MEM_WE_N)[*3] ##1 (state_ff == ST_END && MEM_WE_N);
  endproperty
  a_row_write: assert property (p_row_write) else $error("row write pulse length wrong"); // R11

  property p_row_read;
    (state_ff == ST_SETUP && !wr_ff && long_ff && pwr_ready_ff)
      |=> (state_ff == ST_ACC)[*5] ##1 RSP_VALID;
  endproperty
  a_row_read: assert property (p_row_read) else $error("row read returned early or late"); // R11

  property p_page_write;
    (state_ff == ST_SETUP && wr_ff && !long_ff && pwr_ready_ff)
      |=> state_ff == ST_ACC ##1 (state_ff == ST_END && RSP_VALID);
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write length wrong"); // R10

  // Registered strobes already limit the rate; this guards against a shortcut path
  property p_page_rate;
    $fell(MEM_WE_N) |=> (!$fell(MEM_WE_N)) [*3];
  endproperty
  a_page_rate: assert property (p_page_rate) else $error("write pulses too close"); // R03

  property p_keep_ce;
    (state_ff == ST_END && keep_ff && pwr_ready_ff) |=> !MEM_CE_N && state_ff == ST_IDLE;
  endproperty
  a_keep_ce: assert property (p_keep_ce) else $error("enable released in held mode"); // R02

  property p_toggle_ce;
    (state_ff == ST_END && !keep_ff) |=> MEM_CE_N [*2];
  endproperty
  a_toggle_ce: assert property (p_toggle_ce) else $error("enable not released for precharge"); // R06

  property p_read_lanes;
    (state_ff == ST_ACC && !wr_ff) |-> !MEM_DQ_OE && !MEM_OE_N;
  endproperty
  a_read_lanes: assert property (p_read_lanes) else $error("bus driven during read"); // R08

  property p_byte_one;
    (state_ff == ST_ACC && bm_ff) |-> (MEM_HIGH_BYTE_SELECT_N != MEM_LOW_BYTE_SELECT_N)
      && (MEM_LOW_BYTE_SELECT_N == bsel_ff);
  endproperty
  a_byte_one: assert property (p_byte_one) else $error("byte mode select wrong"); // R12

  property p_byte_dup;
    (state_ff == ST_ACC && bm_ff && wr_ff) |-> MEM_DQ_O[15:8] == MEM_DQ_O[7:0];
  endproperty
  a_byte_dup: assert property (p_byte_dup) else $error("byte lanes differ"); // R09

  c_page_read: cover property (state_ff == ST_SETUP && !long_ff && !wr_ff);
  c_row_change: cover property (state_ff == ST_SETUP && long_ff && !ce_n_ff);
  c_byte_write: cover property (state_ff == ST_ACC && bm_ff && wr_ff);
  c_precharge: cover property (state_ff == ST_PREC ##1 state_ff == ST_IDLE);
endmodule : fmhc_ctrl

/* File: testbench/fmhc_mem_model.sv */
// Behavioural model of the SRAM-style nonvolatile memory on the far side of the pins.
// Assumes the bench resolves DQ and feeds the bus level back on din.
`timescale 1ns/1ns
module fmhc_mem_model (
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic hb_n,
  input wire logic lb_n,
  input wire logic [17:0] addr,
  input wire logic [15:0] din,
  input wire logic pwr_ok,
  output logic [15:0] dout,
  output logic corrupt
);
  logic [15:0] mem [0:262143];
  logic [15:0] q;
  logic wr_act;
  logic rd_en;
  // Whole array cleared so untouched words read as zero, not unknown
  initial begin
    corrupt = 1'b0;
    for (int i = 0; i < 262144; i++) begin
      mem[i] = 16'h0000;
    end
  end
  // Write ends on whichever strobe rises first, no enable edge needed
  assign wr_act = !ce_n && !we_n;
  always @(negedge wr_act) begin
    mem[addr] = {(!hb_n ? din[15:8] : mem[addr][15:8]),
                 (!lb_n ? din[7:0] : mem[addr][7:0])};
  end
  // Data follows the address while enabled, page or new row alike
  assign rd_en = !ce_n && !oe_n && we_n;
  // Unselected lanes show the inverse, so a stale sample cannot match
  always @* begin
    q = mem[addr];
    dout[15:8] = (rd_en && !hb_n) ? q[15:8] : ~q[15:8];
    dout[7:0] = (rd_en && !lb_n) ? q[7:0] : ~q[7:0];
  end
  // Both strobes low on bad power would destroy data
  always @* if (!pwr_ok && wr_act) corrupt = 1'b1;
endmodule : fmhc_mem_model

/* File: testbench/test_async_nv_sram_bus_interface.sv */
// Self-checking bench for the host-side memory controller.
// Assumes the memory model above; byte mode ties both DQ lanes together.
`timescale 1ns/1ns
module test_async_nv_sram_bus_interface;
  import fmhc_pkg::*;
  `define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
  localparam int PU = 8;
  logic clk, rst, pwr_ok, keep, bmode, rv, rw;
  logic [REQ_ADDR_W-1:0] raddr;
  logic [DATA_W-1:0] wd, rdata, dqo, dqi, mdout, q;
  logic [ADDR_W-1:0] maddr;
  logic [1:0] be;
  logic [7:0] lane;
  logic rdy, rspv, ce_n, we_n, oe_n, hb_n, lb_n, dqoe, corrupt;
  int errors = 0;
  int n_tests = 0;
  int n;

  fmhc_ctrl #(.PU_CYC(PU)) dut (
    .SYS_CLK(clk),
    .SYS_RST(rst),
    .PWR_OK(pwr_ok),
    .KEEP_CE(keep),
    .BYTE_MODE(bmode),
    .REQ_VALID(rv),
    .REQ_READY(rdy),
    .REQ_WRITE(rw),
    .REQ_ADDR(raddr),
    .REQ_WDATA(wd),
    .REQ_BE(be),
    .RSP_VALID(rspv),
    .RSP_RDATA(rdata),
    .MEM_CE_N(ce_n),
    .MEM_WE_N(we_n),
    .MEM_OE_N(oe_n),
    .MEM_HIGH_BYTE_SELECT_N(hb_n),
    .MEM_LOW_BYTE_SELECT_N(lb_n),
    .MEM_ADDR(maddr),
    .MEM_DQ_I(dqi),
    .MEM_DQ_O(dqo),
    .MEM_DQ_OE(dqoe)
  );
  fmhc_mem_model mem (
    .ce_n(ce_n),
    .we_n(we_n),
    .oe_n(oe_n),
    .hb_n(hb_n),
    .lb_n(lb_n),
    .addr(maddr),
    .din(dqi),
    .pwr_ok(pwr_ok),
    .dout(mdout),
    .corrupt(corrupt)
  );
  // Bus level; tied lanes carry whichever byte is selected
  assign lane = !hb_n ? mdout[15:8] : mdout[7:0];
  assign dqi = dqoe ? dqo : (bmode ? {lane, lane} : mdout);

  always #25 clk = ~clk;

  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // Bounded wait for ready, counted in cycles
  task automatic wait_rdy();
    n = 0;
    while (rdy !== 1'b1) begin
      @(negedge clk);
      n++;
      if (n > 200) begin
        errors++;
        give_verdict();
      end
    end
  endtask : wait_rdy

  // One request; latency counted in edges after the accept edge
  task automatic op(input logic w, input logic [18:0] a, input logic [15:0] d,
      input logic [1:0] b, input logic k, input int lat);
    wait_rdy();
    rw = w;
    raddr = a;
    wd = d;
    be = b;
    keep = k;
    rv = 1'b1;
    @(negedge clk);
    rv = 1'b0;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (rspv !== 1'b1 && n < 20);
    `CHK("latency", lat, n)
    // A response that never comes ends the run as a failure
    if (n >= 20) begin
      give_verdict();
    end else begin
      q = rdata;
    end
  endtask : op

  task automatic t_reset();
    `CHK("ce_n", 1'b1, ce_n)
    `CHK("we_n", 1'b1, we_n)
    `CHK("dq_oe", 1'b0, dqoe)
    `CHK("ready", 1'b0, rdy)
    rst = 1'b0;
    wait_rdy();
    // Two synchroniser cycles plus the settle count
    `CHK("powerup", PU + 2, n)
  endtask : t_reset

  task automatic t_toggle();
    // Edges after accept: row write 4, page write 2, row read 6, page read 4
    op(1'b1, 19'h5, 16'h1234, 2'h3, 1'b0, 4);
    @(negedge clk);
    `CHK("ce_n idle", 1'b1, ce_n)
    op(1'b0, 19'h5, 16'h0000, 2'h3, 1'b0, 6);
    `CHK("rdata", 16'h1234, q)
  endtask : t_toggle

  task automatic t_lanes();
    op(1'b1, 19'h5, 16'habcd, 2'h1, 1'b0, 4);
    op(1'b1, 19'h5, 16'h99ee, 2'h2, 1'b0, 4);
    op(1'b0, 19'h5, 16'h0000, 2'h3, 1'b0, 6);
    `CHK("lanes", 16'h99cd, q)
  endtask : t_lanes

  task automatic t_page();
    op(1'b1, 19'h8, 16'h1111, 2'h3, 1'b1, 4);
    repeat (4) @(negedge clk);
    `CHK("ce_n held", 1'b0, ce_n)
    op(1'b1, 19'h9, 16'h2222, 2'h3, 1'b1, 2);
    op(1'b0, 19'h8, 16'h0000, 2'h3, 1'b1, 4);
    `CHK("page rd", 16'h1111, q)
    op(1'b1, 19'h10, 16'h3333, 2'h3, 1'b1, 4);
    op(1'b0, 19'h9, 16'h0000, 2'h3, 1'b0, 6);
    `CHK("row rd", 16'h2222, q)
  endtask : t_page

  task automatic t_byte();
    bmode = 1'b1;
    op(1'b1, {1'b1, 18'h3}, 16'h00a5, 2'h0, 1'b0, 4);
    op(1'b1, {1'b0, 18'h3}, 16'h005a, 2'h0, 1'b0, 4);
    op(1'b0, {1'b1, 18'h3}, 16'h0000, 2'h0, 1'b0, 6);
    `CHK("byte rd", 16'h00a5, q)
    bmode = 1'b0;
    op(1'b0, 19'h3, 16'h0000, 2'h3, 1'b0, 6);
    `CHK("word rd", 16'ha55a, q)
  endtask : t_byte

  task automatic t_power();
    op(1'b0, 19'h8, 16'h0000, 2'h3, 1'b1, 6);
    pwr_ok = 1'b0;
    repeat (4) @(negedge clk);
    `CHK("ready off", 1'b0, rdy)
    `CHK("we_n off", 1'b1, we_n)
    pwr_ok = 1'b1;
    op(1'b0, 19'h8, 16'h0000, 2'h3, 1'b0, 6);
    `CHK("kept", 16'h1111, q)
    `CHK("corrupt", 1'b0, corrupt)
  endtask : t_power

  // Main sequence, inputs change on falling edges only
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    pwr_ok = 1'b1;
    {keep, bmode, rv, rw, raddr, wd, be} = '0;
    repeat (12) @(negedge clk);
    t_reset();
    t_toggle();
    t_lanes();
    t_page();
    t_byte();
    t_power();
    give_verdict();
  end
endmodule : test_async_nv_sram_bus_interface
